// [logic/ddi_digital_inputs.sv]
// Programmable digital input function decoder for a drive
// Function
// - Alarm-clear input clears resettable alarms on rising edge; locked alarms stay.
// - Inverted coast input low switches off the power stage at once.
// - Combined coast-and-clear low coasts; alarm clear on its falling edge.
// - Inverted DC brake low brakes for set time if current and time nonzero.
// - Interlock coasts like inverted coast and raises a clearable external fault.
// - Run input high requests run, low requests stop.
// - Direction input reverses when high, never starts, ignored in closed loop.
// - Reverse-and-run sets run and direction; inactive in closed loop.
// - Freeze reference holds value; kept across stop, cleared to zero by reset.
// - Freeze output holds frequency; run input cannot stop, only coast, DC brake, a missing permit or off mode.
// - Two setup inputs pick set 1 to 4 when multi-set mode chosen.
// - Preset enable picks remote or preset; two bits pick preset 1 to 4.
// - Speed up/down act only when frozen, ramping at configured rates.
// - Qualified 3 ms pulse and 3 ms pause steps the frozen value once.
// - Run needs run-permit too; any permit input high satisfies it.
// - Jog forces jog frequency unless coast or DC brake; runs unless coast, DC brake or a missing permit stops it.
// - Programming lock rejects panel writes but accepts serial bus writes.
// - Pulse frequency maps linearly from 0 Hz to minimum up to maximum reference.
// - Hand input runs when high; low gives off/stop unless auto; beats panel.
// - Auto input permits terminal or serial run, beats hand; neither gives off.
// - Latched run starts on a 3 ms pulse without stop; inverted stop ends it.
// - Off-stop and inverted stop ramp down; stop and run ignored in current limit.
`timescale 1ns/10ps
module ddi_digital_inputs
	import ddi_pkg::*;
#(
	parameter int MIN_CYC = MIN_PULSE_CYC,
	parameter int GATE = GATE_CYC,
	parameter int FILT_CYC = FILTER_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [NUM_IN-1:0] term_in,
	input wire logic [NUM_IN-1:0][FN_W-1:0] fn_cfg,
	input wire logic alarm_locked,
	input wire logic stop_key,
	input wire logic closed_loop,
	input wire logic dc_current_nz,
	input wire logic dc_time_nz,
	input wire logic [DC_W-1:0] dc_brake_cyc,
	input wire logic multi_setup,
	input wire logic [1:0] setup_cfg,
	input wire logic ref_remote_preset,
	input wire logic [VAL_W-1:0] ref_now,
	input wire logic [VAL_W-1:0] out_freq_now,
	input wire logic [VAL_W-1:0] ramp_up_div,
	input wire logic [VAL_W-1:0] ramp_dn_div,
	input wire logic [VAL_W-1:0] step_ref,
	input wire logic [VAL_W-1:0] step_hz,
	input wire logic current_limit,
	input wire ddi_mode_t panel_mode,
	input wire logic panel_wr_req,
	input wire logic bus_wr_req,
	input wire logic [VAL_W-1:0] ref_min,
	input wire logic [VAL_W-1:0] ref_max,
	input wire logic [VAL_W-1:0] pulse_max,
	output logic alarm_clear,
	output logic coast,
	output logic ext_fault,
	output logic dc_brake,
	output logic run,
	output logic reverse,
	output logic jog,
	output ddi_mode_t run_mode,
	output logic [1:0] setup_sel,
	output logic preset_on,
	output logic [1:0] preset_sel,
	output logic freeze_ref,
	output logic freeze_out,
	output logic [VAL_W-1:0] held_value,
	output logic prog_lock,
	output logic panel_wr_ok,
	output logic bus_wr_ok,
	output logic [VAL_W-1:0] pulse_ref_val
);
	localparam int IW = $clog2(NUM_IN);

	logic [NUM_IN-1:0] lvl, rse, fll, hld, lng, stp;
	logic [FN_NUM-1:0] asg, any_hi, any_lo, any_rise, any_fall, any_held, any_long, any_step;
	logic [IW-1:0] psel;
	logic [VAL_W-1:0] pfreq;
	logic clear_evt;
	logic [DC_W-1:0] dc_cnt;
	logic [DC_W-1:0] next_dc_cnt;
	logic dc_req_d;
	logic latched;
	logic stop_t;
	logic start_t;
	logic permit;
	ddi_mode_t next_mode;
	logic next_run;
	logic [VAL_W-1:0] rcnt;
	logic [VAL_W:0] sum;
	logic [VAL_W:0] diff;
	logic [2*VAL_W-1:0] scaled;

	// ************************************************************
	// Input filters and per-function collection
	// ************************************************************
	ddi_pin_if pin_bus[NUM_IN] ();
	ddi_pin_if pref ();

	for (genvar g = 0; g < NUM_IN; g++) begin : g_in
		ddi_input_filter #(
			.FILT_CYC(FILT_CYC),
			.MIN_CYC(MIN_CYC)
		) u_filt (
			.clk(clk),
			.rst(rst),
			.ce(ce),
			.raw(term_in[g]),
			.pin(pin_bus[g])
		);
		assign lvl[g] = pin_bus[g].level;
		assign rse[g] = pin_bus[g].rise;
		assign fll[g] = pin_bus[g].fall;
		assign hld[g] = pin_bus[g].held;
		assign lng[g] = pin_bus[g].long_hi;
		assign stp[g] = pin_bus[g].step;
	end

	always_comb begin
		asg = '0;
		any_hi = '0;
		any_lo = '0;
		any_rise = '0;
		any_fall = '0;
		any_held = '0;
		any_long = '0;
		any_step = '0;
		psel = '0;
		for (int i = NUM_IN - 1; i >= 0; i--) begin
			asg[fn_cfg[i]] = 1'b1;
			any_hi[fn_cfg[i]] = any_hi[fn_cfg[i]] | lvl[i];
			any_lo[fn_cfg[i]] = any_lo[fn_cfg[i]] | ~lvl[i];
			any_rise[fn_cfg[i]] = any_rise[fn_cfg[i]] | rse[i];
			any_fall[fn_cfg[i]] = any_fall[fn_cfg[i]] | fll[i];
			any_held[fn_cfg[i]] = any_held[fn_cfg[i]] | hld[i];
			any_long[fn_cfg[i]] = any_long[fn_cfg[i]] | lng[i];
			any_step[fn_cfg[i]] = any_step[fn_cfg[i]] | stp[i];
			if (fn_cfg[i] == FN_PULSE_REF) begin
				psel = IW'(i);
			end
		end
	end

	// Lowest terminal assigned to pulse reference feeds the meter
	assign pref.level = lvl[psel];
	assign pref.rise = rse[psel] & asg[FN_PULSE_REF];
	assign pref.fall = fll[psel];
	assign pref.held = hld[psel];
	assign pref.long_hi = lng[psel];
	assign pref.step = stp[psel];

	ddi_pulse_meter #(
		.GATE(GATE),
		.W(VAL_W)
	) u_meter (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.pin(pref),
		.freq(pfreq)
	);

	// ************************************************************
	// Alarm clear, coast and external fault
	// ************************************************************
	assign clear_evt = any_rise[FN_ALARM_CLEAR] | any_fall[FN_FREEWHEEL_AND_CLEAR_LOW];

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			alarm_clear <= 1'b0;
			coast <= 1'b0;
			ext_fault <= 1'b0;
		end else if (ce) begin
			alarm_clear <= (clear_evt | (stop_key & ext_fault)) & ~alarm_locked;
			coast <= any_lo[FN_COAST_LOW] | any_lo[FN_FREEWHEEL_AND_CLEAR_LOW]
				| any_lo[FN_INTERLOCK_LOW];
			if (any_lo[FN_INTERLOCK_LOW]) begin
				ext_fault <= 1'b1;
			end else if (clear_evt | stop_key) begin
				ext_fault <= 1'b0;
			end
		end
	end

	// ************************************************************
	// Timed DC brake
	// ************************************************************
	always_comb begin
		next_dc_cnt = dc_cnt;
		if (any_lo[FN_DC_HOLD_LOW_ACTIVE] && !dc_req_d && dc_current_nz && dc_time_nz) begin
			next_dc_cnt = dc_brake_cyc;
		end else if (dc_cnt != '0) begin
			next_dc_cnt = dc_cnt - 1'b1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dc_cnt <= '0;
			// Request seen as already active, as the filtered pin reads low after reset, so no false start
			dc_req_d <= 1'b1;
			dc_brake <= 1'b0;
		end else if (ce) begin
			dc_cnt <= next_dc_cnt;
			dc_req_d <= any_lo[FN_DC_HOLD_LOW_ACTIVE];
			dc_brake <= (next_dc_cnt != '0);
		end
	end

	// ************************************************************
	// Setup and preset selection
	// ************************************************************
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			setup_sel <= SET_DEFAULT;
			preset_on <= 1'b0;
			preset_sel <= SET_DEFAULT;
		end else if (ce) begin
			setup_sel <= multi_setup ? {any_hi[FN_SETUP_MSB], any_hi[FN_SETUP_LSB]}
				: setup_cfg;
			preset_on <= ref_remote_preset & any_hi[FN_PRESET_ON];
			preset_sel <= {any_hi[FN_PRESET_MSB], any_hi[FN_PRESET_LSB]};
		end
	end

	// ************************************************************
	// Frozen value with speed up and down
	// ************************************************************
	assign sum = {1'b0, held_value} + {1'b0, (freeze_ref ? step_ref : step_hz)};
	assign diff = {1'b0, held_value} - {1'b0, (freeze_ref ? step_ref : step_hz)};

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			freeze_ref <= 1'b0;
			freeze_out <= 1'b0;
			held_value <= '0;
			rcnt <= '0;
		end else if (ce) begin
			freeze_ref <= any_hi[FN_FREEZE_REF];
			freeze_out <= any_hi[FN_FREEZE_OUT];
			if ((any_hi[FN_FREEZE_REF] | any_hi[FN_FREEZE_OUT]) && !(freeze_ref | freeze_out)) begin
				held_value <= any_hi[FN_FREEZE_REF] ? ref_now : out_freq_now;
				rcnt <= '0;
			end else if (freeze_ref | freeze_out) begin
				if (any_step[FN_SPEED_DOWN]) begin
					held_value <= diff[VAL_W] ? '0 : diff[VAL_W-1:0];
				end else if (any_step[FN_SPEED_UP]) begin
					held_value <= sum[VAL_W] ? VAL_MAX : sum[VAL_W-1:0];
				end else if (any_held[FN_SPEED_DOWN] | any_held[FN_SPEED_UP]) begin
					if (rcnt >= (any_held[FN_SPEED_DOWN] ? ramp_dn_div : ramp_up_div)) begin
						rcnt <= '0;
						if (any_held[FN_SPEED_DOWN] && held_value != '0) begin
							held_value <= held_value - 1'b1;
						end else if (!any_held[FN_SPEED_DOWN] && held_value != VAL_MAX) begin
							held_value <= held_value + 1'b1;
						end
					end else begin
						rcnt <= rcnt + 1'b1;
					end
				end else begin
					rcnt <= '0;
				end
			end
		end
	end

	// ************************************************************
	// Hand, off and auto mode
	// ************************************************************
	always_comb begin
		if (any_hi[FN_AUTO]) begin
			next_mode = MODE_AUTO;
		end else if (any_hi[FN_HAND]) begin
			next_mode = MODE_HAND;
		end else if (asg[FN_HAND] | asg[FN_AUTO]) begin
			next_mode = MODE_OFF;
		end else begin
			next_mode = panel_mode;
		end
	end

	// ************************************************************
	// Run, direction, jog and latched run
	// ************************************************************
	assign stop_t = any_hi[FN_OFF_STOP] | any_lo[FN_STOP_LOW];
	assign start_t = any_hi[FN_RUN] | (any_hi[FN_REV_RUN] & ~closed_loop) | latched;
	assign permit = ~asg[FN_PERMIT] | any_hi[FN_PERMIT];

	always_comb begin
		next_run = 1'b0;
		unique case (run_mode)
			MODE_OFF: next_run = 1'b0;
			MODE_HAND: next_run = 1'b1;
			MODE_AUTO: next_run = freeze_out ? (run | start_t) : (start_t & ~stop_t);
			default: next_run = 1'b0;
		endcase
		if (any_hi[FN_JOG]) begin
			next_run = 1'b1;
		end
		if (coast || dc_brake || !permit) begin
			next_run = 1'b0;
		end else if (current_limit) begin
			next_run = run;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			latched <= 1'b0;
		end else if (ce) begin
			if (any_lo[FN_STOP_LOW] || coast) begin
				latched <= 1'b0;
			end else if (any_long[FN_LATCHED_RUN] && !stop_t) begin
				latched <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			run_mode <= MODE_OFF;
			run <= 1'b0;
			reverse <= 1'b0;
			jog <= 1'b0;
		end else if (ce) begin
			run_mode <= next_mode;
			run <= next_run;
			reverse <= (any_hi[FN_REVERSE] | any_hi[FN_REV_RUN]) & ~closed_loop;
			jog <= any_hi[FN_JOG] & ~coast & ~dc_brake;
		end
	end

	// ************************************************************
	// Programming lock and pulse reference scaling
	// ************************************************************
	assign scaled = (pfreq > pulse_max ? pulse_max : pfreq) * (ref_max - ref_min);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prog_lock <= 1'b0;
			panel_wr_ok <= 1'b0;
			bus_wr_ok <= 1'b0;
			pulse_ref_val <= '0;
		end else if (ce) begin
			prog_lock <= any_hi[FN_PROG_LOCK];
			panel_wr_ok <= panel_wr_req & ~any_hi[FN_PROG_LOCK];
			bus_wr_ok <= bus_wr_req;
			pulse_ref_val <= (pulse_max == '0) ? ref_min
				: ref_min + VAL_W'(scaled / pulse_max);
		end
	end

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_latch_pulse;
		ce && any_long[FN_LATCHED_RUN] && !stop_t && !coast;
	endsequence

	sequence s_latch_hold;
		ce && !any_lo[FN_STOP_LOW] && !coast;
	endsequence

	chk_alarm_clear_edge: assert property (ce && any_rise[FN_ALARM_CLEAR] && !alarm_locked |=> alarm_clear) else $error("alarm clear missed");
	chk_locked_alarm_kept: assert property (ce && alarm_locked |=> !alarm_clear) else $error("locked alarm cleared");
	chk_coast_stops_run: assert property (ce && any_lo[FN_COAST_LOW] |=> coast ##1 !run || !ce) else $error("coast did not stop");
	chk_coast_clear_fall: assert property (ce && any_fall[FN_FREEWHEEL_AND_CLEAR_LOW] && !alarm_locked |=> alarm_clear && coast) else $error("coast and clear wrong");
	chk_dc_gate_off: assert property (ce && !(dc_current_nz && dc_time_nz) && dc_cnt == '0 |=> !dc_brake) else $error("brake without settings");
	chk_fault_raise: assert property (ce && any_lo[FN_INTERLOCK_LOW] |=> ext_fault && coast) else $error("interlock fault missing");
	chk_reverse_closed: assert property (ce && closed_loop |=> !reverse) else $error("reverse in closed loop");
	chk_setup_map: assert property (ce && multi_setup |=> setup_sel == $past({any_hi[FN_SETUP_MSB], any_hi[FN_SETUP_LSB]})) else $error("setup select wrong");
	chk_permit_and: assert property (ce && asg[FN_PERMIT] && !any_hi[FN_PERMIT] |=> !run) else $error("run without permit");
	chk_lock_panel: assert property (ce && any_hi[FN_PROG_LOCK] |=> !panel_wr_ok && bus_wr_ok == $past(bus_wr_req)) else $error("lock handling wrong");
	chk_latch_start: assert property (s_latch_pulse ##1 s_latch_hold |=> latched) else $error("latched run not held");
	chk_hand_runs: assert property (ce && any_hi[FN_HAND] && !any_hi[FN_AUTO] |=> run_mode == MODE_HAND) else $error("hand mode missed");
endmodule // ddi_digital_inputs

// [logic/ddi_pkg.sv]
// Shared constants and types for the digital input function decoder
package ddi_pkg;
	localparam int CLK_HZ = 100_000_000;
	localparam int MIN_PULSE_MS = 3;
	localparam int MIN_PULSE_CYC = (MIN_PULSE_MS * CLK_HZ + 999) / 1000;
	localparam int FILTER_CYC = 16;
	localparam int GATE_MS = 1000;
	localparam int GATE_CYC = GATE_MS * (CLK_HZ / 1000);
	localparam int NUM_IN = 8;
	localparam int FN_W = 5;
	localparam int FN_NUM = 2 ** FN_W;
	localparam int VAL_W = 16;
	localparam int DC_W = 24;
	localparam logic [VAL_W-1:0] VAL_MAX = 16'hFFFF;
	localparam logic [1:0] SET_DEFAULT = 2'h0;

	typedef enum logic [FN_W-1:0] {
		FN_NONE = 5'h00,
		FN_ALARM_CLEAR = 5'h01,
		FN_COAST_LOW = 5'h02,
		FN_FREEWHEEL_AND_CLEAR_LOW = 5'h03,
		FN_DC_HOLD_LOW_ACTIVE = 5'h04,
		FN_INTERLOCK_LOW = 5'h05,
		FN_RUN = 5'h06,
		FN_REVERSE = 5'h07,
		FN_REV_RUN = 5'h08,
		FN_FREEZE_REF = 5'h09,
		FN_FREEZE_OUT = 5'h0A,
		FN_SETUP_LSB = 5'h0B,
		FN_SETUP_MSB = 5'h0C,
		FN_PRESET_ON = 5'h0D,
		FN_PRESET_LSB = 5'h0E,
		FN_PRESET_MSB = 5'h0F,
		FN_SPEED_DOWN = 5'h10,
		FN_SPEED_UP = 5'h11,
		FN_PERMIT = 5'h12,
		FN_JOG = 5'h13,
		FN_PROG_LOCK = 5'h14,
		FN_PULSE_REF = 5'h15,
		FN_HAND = 5'h16,
		FN_AUTO = 5'h17,
		FN_LATCHED_RUN = 5'h18,
		FN_OFF_STOP = 5'h19,
		FN_STOP_LOW = 5'h1A
	} ddi_fn_t;

	typedef enum logic [2:0] {
		MODE_OFF = 3'b001,
		MODE_HAND = 3'b010,
		MODE_AUTO = 3'b100
	} ddi_mode_t;
endpackage

// [logic/ddi_pin_if.sv]
// Filtered terminal events passed from a pin filter to the decoder
`timescale 1ns/10ps
interface ddi_pin_if;
	logic level;
	logic rise;
	logic fall;
	logic held;
	logic long_hi;
	logic step;
	modport src(output level, rise, fall, held, long_hi, step);
	modport dst(input level, rise, fall, held, long_hi, step);
endinterface

// [logic/ddi_input_filter.sv]
// Synchroniser, glitch filter and pulse timing for one input terminal
`timescale 1ns/10ps
module ddi_input_filter
	import ddi_pkg::*;
#(
	parameter int FILT_CYC = FILTER_CYC,
	parameter int MIN_CYC = MIN_PULSE_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic raw,
	ddi_pin_if.src pin
);
	localparam int FW = $clog2(FILT_CYC + 1);
	localparam int CW = $clog2(MIN_CYC + 1);
	localparam logic [FW-1:0] FILT_LAST = FW'(FILT_CYC - 1);
	localparam logic [CW-1:0] MIN_V = CW'(MIN_CYC);
	localparam logic [CW-1:0] MIN_LAST = CW'(MIN_CYC - 1);

	logic sync1;
	logic sync2;
	logic [FW-1:0] fcnt;
	logic [CW-1:0] hcnt;
	logic [CW-1:0] lcnt;
	logic armed;

	// ************************************************************
	// Synchroniser and filter
	// ************************************************************
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sync1 <= 1'b0;
			sync2 <= 1'b0;
		end else if (ce) begin
			sync1 <= raw;
			sync2 <= sync1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			fcnt <= '0;
			pin.level <= 1'b0;
			pin.rise <= 1'b0;
			pin.fall <= 1'b0;
		end else if (ce) begin
			pin.rise <= 1'b0;
			pin.fall <= 1'b0;
			if (sync2 == pin.level) begin
				fcnt <= '0;
			end else if (fcnt == FILT_LAST) begin
				fcnt <= '0;
				pin.level <= sync2;
				pin.rise <= sync2;
				pin.fall <= ~sync2;
			end else begin
				fcnt <= fcnt + 1'b1;
			end
		end
	end

	// ************************************************************
	// High and low time measurement
	// ************************************************************
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hcnt <= '0;
			lcnt <= '0;
		end else if (ce) begin
			hcnt <= (pin.level && hcnt != MIN_V) ? hcnt + 1'b1 : (pin.level ? hcnt : '0);
			lcnt <= (!pin.level && lcnt != MIN_V) ? lcnt + 1'b1 : (pin.level ? '0 : lcnt);
		end
	end

	assign pin.held = pin.level && (hcnt == MIN_V);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			armed <= 1'b0;
			pin.long_hi <= 1'b0;
			pin.step <= 1'b0;
		end else if (ce) begin
			pin.long_hi <= pin.level && (hcnt == MIN_LAST);
			pin.step <= armed && !pin.level && (lcnt == MIN_LAST);
			if (pin.fall) begin
				armed <= (hcnt == MIN_V);
			end else if (pin.level || lcnt == MIN_LAST) begin
				armed <= 1'b0;
			end
		end
	end
endmodule // ddi_input_filter

// [logic/ddi_pulse_meter.sv]
// Edge counter giving the pulse frequency over a fixed gate time
`timescale 1ns/10ps
module ddi_pulse_meter
	import ddi_pkg::*;
#(
	parameter int GATE = GATE_CYC,
	parameter int W = VAL_W
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	ddi_pin_if.dst pin,
	output logic [W-1:0] freq
);
	localparam int GW = $clog2(GATE + 1);
	localparam logic [GW-1:0] GATE_LAST = GW'(GATE - 1);
	localparam logic [W-1:0] CNT_MAX = {W{1'b1}};

	logic [GW-1:0] gcnt;
	logic [W-1:0] ecnt;

	// Saturating edge count latched at the end of each gate
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			gcnt <= '0;
			ecnt <= '0;
			freq <= '0;
		end else if (ce) begin
			if (gcnt == GATE_LAST) begin
				gcnt <= '0;
				ecnt <= '0;
				freq <= (pin.rise && ecnt != CNT_MAX) ? ecnt + 1'b1 : ecnt;
			end else begin
				gcnt <= gcnt + 1'b1;
				if (pin.rise && ecnt != CNT_MAX) begin
					ecnt <= ecnt + 1'b1;
				end
			end
		end
	end
endmodule // ddi_pulse_meter

// [bench/ddi_switch_model.sv]
// Model of the external switches wired to the input terminals
`timescale 1ns/10ps
module ddi_switch_model
	import ddi_pkg::*;
(
	input wire logic clk,
	output logic [NUM_IN-1:0] term
);
	initial term = '0;

	// Contacts move just after a clock edge
	task automatic set_pin(input int i, input logic v);
		@(posedge clk);
		#1 term[i] = v;
	endtask

	// Qualified pulse: high time, then pause
	task automatic pulse_pin(input int i, input int hi, input int lo);
		set_pin(i, 1'b1);
		repeat (hi) @(posedge clk);
		#1 term[i] = 1'b0;
		repeat (lo) @(posedge clk);
	endtask
endmodule // ddi_switch_model

// [bench/ddi_digital_inputs_bench.sv]
// Self-checking bench for the digital input function decoder
`timescale 1ns/10ps
module ddi_digital_inputs_bench
	import ddi_pkg::*;
;
	localparam int MC = 20;
	localparam int ST = 12;
	logic clk, rst, ce, alarm_locked, stop_key, closed_loop, dc_current_nz, dc_time_nz;
	logic multi_setup, ref_remote_preset, current_limit, panel_wr_req, bus_wr_req;
	logic [DC_W-1:0] dc_brake_cyc;
	logic [1:0] setup_cfg, setup_sel, preset_sel;
	logic [VAL_W-1:0] ref_now, out_freq_now, ramp_up_div, ramp_dn_div, step_ref, step_hz;
	logic [VAL_W-1:0] ref_min, ref_max, pulse_max, held_value, pulse_ref_val;
	logic [NUM_IN-1:0][FN_W-1:0] fn_cfg;
	wire logic [NUM_IN-1:0] term_in;
	ddi_mode_t panel_mode, run_mode;
	logic alarm_clear, coast, run, reverse, jog, preset_on, freeze_ref, prog_lock;
	logic ext_fault, dc_brake, freeze_out;
	logic panel_wr_ok, bus_wr_ok;
	int n_errors, total_checks, n_clr, n_pok, n_bok;

	ddi_switch_model sw (.clk(clk), .term(term_in));

	ddi_digital_inputs #(.MIN_CYC(MC), .GATE(200), .FILT_CYC(2)) dut (
		.clk(clk), .rst(rst), .ce(ce), .term_in(term_in), .fn_cfg(fn_cfg),
		.alarm_locked(alarm_locked), .stop_key(stop_key), .closed_loop(closed_loop),
		.dc_current_nz(dc_current_nz), .dc_time_nz(dc_time_nz), .dc_brake_cyc(dc_brake_cyc),
		.multi_setup(multi_setup), .setup_cfg(setup_cfg), .ref_remote_preset(ref_remote_preset),
		.ref_now(ref_now), .out_freq_now(out_freq_now), .ramp_up_div(ramp_up_div),
		.ramp_dn_div(ramp_dn_div), .step_ref(step_ref), .step_hz(step_hz),
		.current_limit(current_limit), .panel_mode(panel_mode), .panel_wr_req(panel_wr_req),
		.bus_wr_req(bus_wr_req), .ref_min(ref_min), .ref_max(ref_max), .pulse_max(pulse_max),
		.alarm_clear(alarm_clear), .coast(coast), .ext_fault(ext_fault), .dc_brake(dc_brake),
		.run(run),
		.reverse(reverse), .jog(jog), .run_mode(run_mode), .setup_sel(setup_sel),
		.preset_on(preset_on), .preset_sel(preset_sel), .freeze_ref(freeze_ref),
		.freeze_out(freeze_out), .held_value(held_value), .prog_lock(prog_lock),
		.panel_wr_ok(panel_wr_ok), .bus_wr_ok(bus_wr_ok), .pulse_ref_val(pulse_ref_val)
	);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// One-cycle outputs are counted as they pass
	always @(posedge clk) begin
		if (alarm_clear === 1'b1) n_clr++;
		if (panel_wr_ok === 1'b1) n_pok++;
		if (bus_wr_ok === 1'b1) n_bok++;
	end

	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic end_sim;
		$display("Checks %0d, errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	initial begin
		settle(5000);
		n_errors++;
		end_sim();
	end

	// ****************************************
	// Stimulus
	// ****************************************
	initial begin
		rst = 1'b1;
		ce = 1'b1;
		{alarm_locked, stop_key, closed_loop, dc_current_nz, dc_time_nz, multi_setup} = '0;
		{ref_remote_preset, current_limit, panel_wr_req, bus_wr_req} = '0;
		{setup_cfg, out_freq_now, step_hz, ref_min} = '0;
		dc_brake_cyc = 24'h00_0010;
		ref_now = 16'h1000;
		step_ref = 16'h0010;
		ramp_up_div = 16'hFFFF;
		ramp_dn_div = 16'hFFFF;
		ref_max = 16'h0100;
		pulse_max = 16'h0010;
		panel_mode = MODE_AUTO;
		fn_cfg[0] = FN_ALARM_CLEAR;
		fn_cfg[1] = FN_COAST_LOW;
		fn_cfg[2] = FN_RUN;
		fn_cfg[3] = FN_REVERSE;
		fn_cfg[4] = FN_PERMIT;
		fn_cfg[5] = FN_SETUP_LSB;
		fn_cfg[6] = FN_SETUP_MSB;
		fn_cfg[7] = FN_JOG;
		settle(3);
		chk("run_mode", 16'(run_mode), 16'(MODE_OFF));
		chk("held_value", held_value, 16'h0000);
		rst = 1'b0;
		sw.set_pin(1, 1'b1);
		settle(ST);
		chk("coast", 16'(coast), 16'h0000);
		sw.pulse_pin(0, 4, 4);
		settle(ST);
		chk("clear count", 16'(n_clr), 16'h0001);
		alarm_locked = 1'b1;
		sw.pulse_pin(0, 4, 4);
		settle(ST);
		chk("locked clear", 16'(n_clr), 16'h0001);
		alarm_locked = 1'b0;
		sw.set_pin(2, 1'b1);
		settle(ST);
		chk("run no permit", 16'(run), 16'h0000);
		sw.set_pin(4, 1'b1);
		sw.set_pin(3, 1'b1);
		settle(ST);
		chk("run", 16'(run), 16'h0001);
		chk("reverse", 16'(reverse), 16'h0001);
		current_limit = 1'b1;
		sw.set_pin(2, 1'b0);
		settle(ST);
		chk("run in limit", 16'(run), 16'h0001);
		current_limit = 1'b0;
		settle(ST);
		chk("run stop", 16'(run), 16'h0000);
		chk("reverse no start", 16'(run), 16'h0000);
		sw.set_pin(3, 1'b0);
		sw.set_pin(7, 1'b1);
		settle(ST);
		chk("jog", 16'(jog), 16'h0001);
		chk("jog run", 16'(run), 16'h0001);
		sw.set_pin(1, 1'b0);
		settle(ST);
		chk("coast on", 16'(coast), 16'h0001);
		chk("jog coast run", 16'(run), 16'h0000);
		sw.set_pin(7, 1'b0);
		sw.set_pin(1, 1'b1);
		multi_setup = 1'b1;
		for (int k = 0; k < 4; k++) begin
			sw.set_pin(5, k[0]);
			sw.set_pin(6, k[1]);
			settle(ST);
			chk("setup_sel", 16'(setup_sel), 16'(k));
		end
		fn_cfg[5] = FN_PRESET_LSB;
		fn_cfg[6] = FN_PRESET_MSB;
		fn_cfg[7] = FN_PRESET_ON;
		ref_remote_preset = 1'b1;
		settle(ST);
		chk("preset off", 16'(preset_on), 16'h0000);
		sw.set_pin(7, 1'b1);
		for (int k = 0; k < 4; k++) begin
			sw.set_pin(5, k[0]);
			sw.set_pin(6, k[1]);
			settle(ST);
			chk("preset_on", 16'(preset_on), 16'h0001);
			chk("preset_sel", 16'(preset_sel), 16'(k));
		end
		fn_cfg[0] = FN_PROG_LOCK;
		sw.set_pin(0, 1'b1);
		settle(ST);
		chk("prog_lock", 16'(prog_lock), 16'h0001);
		panel_wr_req = 1'b1;
		bus_wr_req = 1'b1;
		settle(1);
		panel_wr_req = 1'b0;
		bus_wr_req = 1'b0;
		settle(4);
		chk("panel write", 16'(n_pok), 16'h0000);
		chk("bus write", 16'(n_bok), 16'h0001);
		fn_cfg[2] = FN_SPEED_UP;
		fn_cfg[3] = FN_FREEZE_REF;
		sw.pulse_pin(2, MC + 4, MC + 4);
		settle(ST);
		chk("held idle", held_value, 16'h0000);
		sw.set_pin(3, 1'b1);
		settle(ST);
		chk("freeze_ref", 16'(freeze_ref), 16'h0001);
		chk("held entry", held_value, 16'h1000);
		sw.pulse_pin(2, MC + 4, MC + 4);
		settle(ST);
		chk("held step", held_value, 16'h1010);
		sw.set_pin(3, 1'b0);
		settle(ST);
		chk("held kept", held_value, 16'h1010);
		fn_cfg[2] = FN_SPEED_DOWN;
		fn_cfg[3] = FN_FREEZE_OUT;
		out_freq_now = 16'h0200;
		step_hz = 16'h0001;
		sw.set_pin(3, 1'b1);
		settle(ST);
		chk("freeze_out", 16'(freeze_out), 16'h0001);
		chk("held out", held_value, 16'h0200);
		sw.pulse_pin(2, MC + 4, MC + 4);
		settle(ST);
		chk("held down", held_value, 16'h01FF);
		// 25 rises per 200-cycle gate, scaled by 256/50
		fn_cfg[5] = FN_PULSE_REF;
		pulse_max = 16'h0032;
		repeat (60) sw.pulse_pin(5, 4, 3);
		settle(1);
		chk("pulse_ref_val", pulse_ref_val, 16'h0080);
		dc_current_nz = 1'b1;
		dc_time_nz = 1'b1;
		fn_cfg[6] = FN_DC_HOLD_LOW_ACTIVE;
		sw.set_pin(6, 1'b0);
		settle(ST);
		chk("dc_brake on", 16'(dc_brake), 16'h0001);
		settle(ST);
		chk("dc_brake end", 16'(dc_brake), 16'h0000);
		fn_cfg[0] = FN_INTERLOCK_LOW;
		panel_wr_req = 1'b1;
		settle(1);
		panel_wr_req = 1'b0;
		sw.set_pin(0, 1'b0);
		settle(ST);
		chk("panel unlocked", 16'(n_pok), 16'h0001);
		chk("ext_fault", 16'(ext_fault), 16'h0001);
		chk("fault coast", 16'(coast), 16'h0001);
		sw.set_pin(0, 1'b1);
		settle(ST);
		stop_key = 1'b1;
		settle(1);
		stop_key = 1'b0;
		settle(2);
		chk("fault clear", 16'(ext_fault), 16'h0000);
		chk("stop clear", 16'(n_clr), 16'h0002);
		fn_cfg[1] = FN_FREEWHEEL_AND_CLEAR_LOW;
		sw.set_pin(1, 1'b0);
		settle(ST);
		chk("freewheel clear", 16'(n_clr), 16'h0003);
		chk("freewheel coast", 16'(coast), 16'h0001);
		sw.set_pin(1, 1'b1);
		fn_cfg[7] = FN_HAND;
		settle(ST);
		chk("hand mode", 16'(run_mode), 16'(MODE_HAND));
		chk("hand run", 16'(run), 16'h0001);
		fn_cfg[3] = FN_STOP_LOW;
		fn_cfg[5] = FN_AUTO;
		sw.set_pin(5, 1'b1);
		settle(ST);
		chk("auto mode", 16'(run_mode), 16'(MODE_AUTO));
		chk("auto idle", 16'(run), 16'h0000);
		fn_cfg[2] = FN_LATCHED_RUN;
		sw.pulse_pin(2, MC + 2, 4);
		settle(ST);
		chk("latched run", 16'(run), 16'h0001);
		sw.set_pin(3, 1'b0);
		settle(ST);
		chk("stop low", 16'(run), 16'h0000);
		sw.set_pin(3, 1'b1);
		settle(ST);
		chk("latch cleared", 16'(run), 16'h0000);
		fn_cfg[7] = FN_REVERSE;
		closed_loop = 1'b1;
		settle(2);
		chk("reverse closed", 16'(reverse), 16'h0000);
		end_sim();
	end
endmodule // ddi_digital_inputs_bench
